// ==== rtl/cmp_pkg.sv ====
// Purpose: constants and types for the current mode pwm core
// Assumes: 100 MHz timing clock mclk_i
// Notes: analog thresholds live in external comparators; this logic sequences them
// Summary of operation
// - sense plus ramp above feedback resets the pulse latch, ending on-time.
// - ramp is held at start while the pulse latch is reset, released when it sets at oscillator turn-on, before the gate turns on.
// - gate stays off about 156 ns after each oscillator turn-on event.
// - sense is scaled by 3.3 before ramp add; done in the analog front end.
// - summed signal feeds duty and soft-start comparators; either ends the pulse.
// - supply above turn-on threshold starts the soft-start phase.
// - soft start rises in 32 steps of 600 us, complete about 19.2 ms after switch-on.
// - at soft-start end the duty-limiting sink is switched off.
// - soft-start duty limit grows from zero to the maximum duty limit.
// - soft start reruns at every protective restart attempt.
// - oscillator runs 67 kHz nominal with plus or minus 4 percent, 4 ms jitter.
// - on-time per period is capped to duty 0.75.
// - 2.7 kHz jitter applies only after soft start has finished.
// - latch set by oscillator pulse, reset by first firing comparator.
// - latch reset turns gate drive off immediately.
// - gate forced low while supply is below undervoltage level.
// - peak limit comparator turns gate off at once every cycle.
// - blanking masks peak limit, burst limit and sense amplifier paths.
// - blanking lasts 220 ns from each gate turn-on.
// - in burst mode the burst limit comparator (0.26 V threshold) is enabled.
// - peak threshold slope compensation is analog; comparator output used as is.
// - supply below 10.5 V off level resets the soft-start counter.
// - burst entered only after feedback below 1.22 V for 20 ms continuously.
// - feedback above 4.5 V leaves burst mode, restoring full peak limit.
package cmp_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned DEAD_TIME_NS = 156;
  localparam int unsigned DEAD_CYC = (DEAD_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned BLANK_TIME_NS = 220;
  localparam int unsigned BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PERIOD_NOM_HZ = 67000;
  localparam int unsigned PERIOD_CYC = (CLK_MHZ * 1000000) / PERIOD_NOM_HZ;
  localparam int unsigned JITTER_HZ = 2700;
  localparam int unsigned JITTER_PERIOD_US = 4000;
  localparam int unsigned JITTER_DEPTH_CYC =
    (PERIOD_CYC * JITTER_HZ) / PERIOD_NOM_HZ;
  localparam int unsigned DMAX_NUM = 3;
  localparam int unsigned DMAX_DEN = 4;
  localparam int unsigned SS_STEPS = 32;
  localparam int unsigned SS_STEP_US = 600;
  localparam int unsigned SS_TOTAL_US = 20000;
  localparam int unsigned BURST_ENTRY_US = 20000;
  localparam int unsigned US_CYC = CLK_MHZ;
  localparam logic [5:0] SS_CNT_RST = 6'h00;

  typedef enum logic [2:0] {
    CMP_ST_OFF = 3'b001,
    CMP_ST_SOFT = 3'b010,
    CMP_ST_RUN = 3'b100
  } cmp_state_t;
endpackage

// ==== rtl/cmp_osc_if.sv ====
`timescale 1ns/1ps
// Purpose: oscillator signals shared by core and oscillator
// Assumes: single clock domain
// Notes: none
interface cmp_osc_if;
  logic jitter_en;
  logic turn_on;
  logic on_window;
  modport osc (input jitter_en, output turn_on, output on_window);
  modport core (output jitter_en, input turn_on, input on_window);
endinterface

// ==== rtl/cmp_oscillator.sv ====
`timescale 1ns/1ps
// Purpose: fixed frequency oscillator with triangular frequency jitter
// Assumes: 100 MHz mclk_i
// Notes: on_window marks the max-duty part of each period
module cmp_oscillator
  import cmp_pkg::*;
#(
  parameter int unsigned PERIOD = PERIOD_CYC,
  parameter int unsigned JDEPTH = JITTER_DEPTH_CYC,
  parameter int unsigned JSTEP_US = JITTER_PERIOD_US / (4 * JITTER_DEPTH_CYC)
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  cmp_osc_if.osc osc
);
  // offset is an 8-bit signed value and the phase counter is 12 bits wide
  if (JDEPTH == 0 || JDEPTH > 32'h0000_007F || JDEPTH >= PERIOD / 4 ||
      PERIOD > 32'h0000_0FFF || JSTEP_US == 0) begin : g_bad_jitter
    $error("cmp_oscillator: bad jitter settings");
  end
  typedef struct packed {
    logic [11:0] ph;
    logic signed [7:0] ofs;
    logic up;
    logic [15:0] tick;
    logic [15:0] us;
  } cmp_osc_st_t;
  cmp_osc_st_t q, d;
  logic [11:0] len;
  always_comb begin
    d = q;
    // period = nominal minus offset, swept +/- depth over the jitter period
    len = 12'(PERIOD - 12'($signed(q.ofs)));
    d.ph = (q.ph + 12'h001 >= len) ? 12'h000 : q.ph + 12'h001;
    d.tick = (q.tick == 16'(US_CYC - 1)) ? 16'h0000 : q.tick + 16'h0001;
    if (q.tick == 16'(US_CYC - 1)) begin
      d.us = (q.us == 16'(JSTEP_US - 1)) ? 16'h0000 : q.us + 16'h0001;
    end
    if (!osc.jitter_en) begin
      d.ofs = 8'sh00;
      d.up = 1'b1;
      d.us = 16'h0000;
    end else if (q.tick == 16'(US_CYC - 1) && q.us == 16'(JSTEP_US - 1)) begin
      if (q.up) begin
        d.ofs = q.ofs + 8'sh01;
        if (q.ofs + 8'sh01 >= $signed(8'(JDEPTH))) d.up = 1'b0;
      end else begin
        d.ofs = q.ofs - 8'sh01;
        // signed compare, else the down sweep turns back at once
        if (q.ofs - 8'sh01 <= -$signed(8'(JDEPTH))) d.up = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign osc.turn_on = (q.ph == 12'h000);
  // max duty 0.75 of the current period
  assign osc.on_window = (16'(q.ph) * 16'(DMAX_DEN) < 16'(len) * 16'(DMAX_NUM));
endmodule

// ==== rtl/cmp_core.sv ====
`timescale 1ns/1ps
// Purpose: current mode pwm sequencing: pulse latch, blanking, soft start, burst
// Assumes: comparator outputs are asynchronous; ramp and soft-start level analog
// Notes: gate_o combinationally drops on turn-off comparators
module cmp_core
  import cmp_pkg::*;
#(
  parameter int unsigned SS_STEP_CYC = SS_STEP_US * US_CYC,
  parameter int unsigned BURST_CYC = BURST_ENTRY_US * US_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic supply_on_i,
  input wire logic supply_ok_i,
  input wire logic restart_i,
  input wire logic duty_comparator_i,
  input wire logic softstart_comparator_i,
  input wire logic peak_limit_comparator_i,
  input wire logic burst_limit_comparator_i,
  input wire logic regulation_feedback_low_i,
  input wire logic regulation_feedback_high_i,
  output logic gate_o,
  output logic ramp_reset_switch_o,
  output logic spike_blank_o,
  output logic [4:0] softstart_level_o,
  output logic softstart_sink_en_o,
  output logic burst_limit_gate_o,
  output logic burst_mode_o
);
  // counters are 20, 22 and 8 bits wide
  if (SS_STEP_CYC < 2 || SS_STEP_CYC > 32'h0010_0000 || BURST_CYC < 2 ||
      BURST_CYC > 32'h0040_0000 || BLANK_CYC < 1 || DEAD_CYC < 1 ||
      DEAD_CYC + BLANK_CYC > 32'h0000_00FF) begin : g_bad_timing
    $error("cmp_core: timing counts out of range");
  end

  cmp_osc_if osc_if ();
  cmp_oscillator u_osc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .osc(osc_if)
  );

  typedef struct packed {
    logic [1:0] s_on;
    logic [1:0] s_ok;
    logic [1:0] s_rst;
    logic [1:0] s_fbl;
    logic [1:0] s_fbh;
    cmp_state_t st;
    logic latch;
    logic [7:0] dead;
    logic [7:0] blank;
    logic [5:0] ss_cnt;
    logic [19:0] ss_tmr;
    logic [21:0] bt;
    logic burst;
  } cmp_core_st_t;
  cmp_core_st_t q, d;

  logic uv_ok;
  logic kill;
  logic blanked;

  // synchronised levels, second stage only read by logic
  assign uv_ok = q.s_ok[1];
  assign blanked = (q.blank != 8'h00) || (q.dead != 8'h00);
  // turn-off paths combinational, gated by blanking
  // comparator inputs arrive already gain scaled and delay compensated
  assign kill = !blanked && (duty_comparator_i
    || softstart_comparator_i
    || peak_limit_comparator_i
    || (q.burst && burst_limit_comparator_i));
  assign osc_if.jitter_en = (q.st == CMP_ST_RUN);

  always_comb begin
    d = q;
    d.s_on = {q.s_on[0], supply_on_i};
    d.s_ok = {q.s_ok[0], supply_ok_i};
    d.s_rst = {q.s_rst[0], restart_i};
    d.s_fbl = {q.s_fbl[0], regulation_feedback_low_i};
    d.s_fbh = {q.s_fbh[0], regulation_feedback_high_i};
    if (q.dead != 8'h00) d.dead = q.dead - 8'h01;
    if (q.blank != 8'h00) d.blank = q.blank - 8'h01;
    // pulse latch: set on oscillator pulse, reset by first firing comparator
    if (osc_if.turn_on && q.st != CMP_ST_OFF) begin
      d.latch = 1'b1;
      d.dead = 8'(DEAD_CYC);
      d.blank = 8'(DEAD_CYC + BLANK_CYC);
    end else if (kill || !osc_if.on_window) begin
      d.latch = 1'b0;
    end
    case (q.st)
      CMP_ST_OFF: begin
        d.ss_cnt = SS_CNT_RST;
        d.ss_tmr = '0;
        d.latch = 1'b0;
        if (q.s_on[1] && uv_ok) d.st = CMP_ST_SOFT;
      end
      CMP_ST_SOFT: begin
        if (q.ss_tmr == 20'(SS_STEP_CYC - 1)) begin
          d.ss_tmr = '0;
          d.ss_cnt = q.ss_cnt + 6'h01;
          if (q.ss_cnt == 6'(SS_STEPS - 1)) d.st = CMP_ST_RUN;
        end else begin
          d.ss_tmr = q.ss_tmr + 20'h00001;
        end
      end
      CMP_ST_RUN: begin
        d.ss_cnt = 6'(SS_STEPS);
      end
      default: d.st = CMP_ST_OFF;
    endcase
    if (!uv_ok || q.s_rst[1]) begin
      d.st = CMP_ST_OFF;
      d.ss_cnt = SS_CNT_RST;
      d.latch = 1'b0;
    end
    // burst entry needs 20 ms continuous low feedback
    if (q.st != CMP_ST_RUN || !q.s_fbl[1] || q.burst) begin
      d.bt = '0;
    end else if (q.bt == 22'(BURST_CYC - 1)) begin
      d.burst = 1'b1;
    end else begin
      d.bt = q.bt + 22'h000001;
    end
    if (q.s_fbh[1] || q.st != CMP_ST_RUN) d.burst = 1'b0;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '{st: CMP_ST_OFF, ss_cnt: SS_CNT_RST, default: '0};
    end else begin
      q <= d;
    end
  end

  assign gate_o = q.latch && q.dead == 8'h00 && !kill && uv_ok;
  assign ramp_reset_switch_o = !q.latch;
  assign spike_blank_o = blanked;
  assign softstart_level_o = q.ss_cnt[5] ? 5'h1F : q.ss_cnt[4:0];
  assign softstart_sink_en_o = (q.st != CMP_ST_RUN);
  assign burst_limit_gate_o = q.burst;
  assign burst_mode_o = q.burst;
endmodule

// ==== testbench/cmp_core_asserts.sv ====
`timescale 1ns/1ps
// Purpose: port checks for cmp_core
// Assumes: one clock, async active high reset
// Notes: kills count only outside the blanking flag
module cmp_core_asserts (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic supply_ok_i,
  input wire logic duty_comparator_i,
  input wire logic softstart_comparator_i,
  input wire logic peak_limit_comparator_i,
  input wire logic burst_limit_comparator_i,
  input wire logic regulation_feedback_high_i,
  input wire logic gate_o,
  input wire logic ramp_reset_switch_o,
  input wire logic spike_blank_o,
  input wire logic [4:0] softstart_level_o,
  input wire logic softstart_sink_en_o,
  input wire logic burst_limit_gate_o,
  input wire logic burst_mode_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // gate stays low for all 15 dead-time cycles after the latch sets
  sequence dead_s;
    !gate_o [*8] ##1 !gate_o [*7];
  endsequence
  // blanking covers the first 22 cycles of each gate pulse
  sequence blank_s;
    spike_blank_o [*8] ##1 spike_blank_o [*8] ##1 spike_blank_o [*6];
  endsequence
  chk_duty_kill: assert property (duty_comparator_i && !spike_blank_o |-> !gate_o)
    else $error("duty kill missed");
  chk_ramp_free: assert property (gate_o |-> !ramp_reset_switch_o)
    else $error("ramp held while gate on");
  chk_dead_time: assert property ($fell(ramp_reset_switch_o) |-> dead_s)
    else $error("gate on inside dead time");
  chk_ss_kill: assert property (softstart_comparator_i && !spike_blank_o |-> !gate_o)
    else $error("soft-start kill missed");
  chk_ss_step: assert property ($changed(softstart_level_o) |-> softstart_level_o ==
    $past(softstart_level_o) + 5'h01 || softstart_level_o == 5'h00)
    else $error("soft-start level jumped");
  chk_sink_off: assert property ($fell(softstart_sink_en_o) |-> softstart_level_o == 5'h1F)
    else $error("sink off early");
  chk_uvlo_low: assert property (!supply_ok_i [*4] |-> !gate_o)
    else $error("gate on under low supply");
  chk_peak_kill: assert property (peak_limit_comparator_i && !spike_blank_o |-> !gate_o)
    else $error("peak kill missed");
  chk_blank_hold: assert property ($rose(gate_o) |-> blank_s)
    else $error("blanking short");
  chk_burst_kill: assert property (burst_limit_comparator_i && burst_limit_gate_o
    && !spike_blank_o |-> !gate_o)
    else $error("burst kill missed");
  chk_burst_exit: assert property (regulation_feedback_high_i [*5] |-> !burst_mode_o)
    else $error("burst not left");
endmodule
bind cmp_core cmp_core_asserts u_cmp_core_asserts (
  .mclk_i(mclk_i),
  .rst_i(rst_i),
  .supply_ok_i(supply_ok_i),
  .duty_comparator_i(duty_comparator_i),
  .softstart_comparator_i(softstart_comparator_i),
  .peak_limit_comparator_i(peak_limit_comparator_i),
  .burst_limit_comparator_i(burst_limit_comparator_i),
  .regulation_feedback_high_i(regulation_feedback_high_i),
  .gate_o(gate_o),
  .ramp_reset_switch_o(ramp_reset_switch_o),
  .spike_blank_o(spike_blank_o),
  .softstart_level_o(softstart_level_o),
  .softstart_sink_en_o(softstart_sink_en_o),
  .burst_limit_gate_o(burst_limit_gate_o),
  .burst_mode_o(burst_mode_o)
);

// ==== testbench/cmp_plant.sv ====
`timescale 1ns/1ps
// Purpose: switch, sense and feedback model
// Assumes: sense rises one step per cycle of gate on
// Notes: comparators are registered, no loop through gate
module cmp_plant (
  input wire logic mclk_i,
  input wire logic gate_i,
  input wire logic sink_i,
  input wire logic [4:0] ss_lvl_i,
  input wire logic [11:0] fdbk_lvl_i,
  input wire logic [11:0] pk_lvl_i,
  output logic duty_o = 1'b0,
  output logic ss_o = 1'b0,
  output logic peak_o = 1'b0,
  output logic burst_o = 1'b0
);
  logic [11:0] cnt_q = 12'h000;
  always_ff @(posedge mclk_i) begin
    cnt_q <= gate_i ? cnt_q + 12'h001 : 12'h000;
    duty_o <= gate_i && cnt_q >= fdbk_lvl_i;
    ss_o <= gate_i && sink_i && cnt_q >= {4'h0, ss_lvl_i, 3'h0};
    peak_o <= gate_i && cnt_q >= pk_lvl_i;
    burst_o <= gate_i && cnt_q >= 12'h03C;
  end
endmodule

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
// Purpose: self-checking bench for cmp_core
// Assumes: plant model closes the sense loop
// Notes: short soft-start and burst counts
module tb
  import cmp_pkg::*;
;
  // soft start outlasts one period, so a pulse meets the soft-start limit
  localparam int SS = 60;
  // edges from supply change to soft-start state through the synchroniser
  localparam int SYNC = 3;
  localparam int BC = 50;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic on = 1'b0, ok = 1'b0, rs = 1'b0, lo = 1'b0, hi = 1'b0;
  logic duty, ssc, peak, bc, gate, ramp, blank, sink, bgate, bmode;
  logic [4:0] lvl;
  logic [11:0] fdbk = 12'hFFF, pk = 12'hFFF;
  int error_cnt = 0, comparisons = 0, seed = 32'hDBB1C1D2, w, t;
  always #5 mclk_i = ~mclk_i;
  cmp_core #(.SS_STEP_CYC(SS), .BURST_CYC(BC)) u_cmp_core (.mclk_i(mclk_i), .rst_i(rst_i),
    .supply_on_i(on), .supply_ok_i(ok), .restart_i(rs), .duty_comparator_i(duty),
    .softstart_comparator_i(ssc), .peak_limit_comparator_i(peak), .burst_limit_comparator_i(bc),
    .regulation_feedback_low_i(lo), .regulation_feedback_high_i(hi), .gate_o(gate),
    .ramp_reset_switch_o(ramp),
    .spike_blank_o(blank), .softstart_level_o(lvl), .softstart_sink_en_o(sink),
    .burst_limit_gate_o(bgate), .burst_mode_o(bmode));
  cmp_plant u_cmp_plant (.mclk_i(mclk_i), .gate_i(gate), .sink_i(sink), .ss_lvl_i(lvl),
    .fdbk_lvl_i(fdbk), .pk_lvl_i(pk), .duty_o(duty), .ss_o(ssc), .peak_o(peak), .burst_o(bc));
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input string m);
    chk(got >= exp - 3 && got <= exp + 3, 1'b1, m);
  endtask
  // width of the gate pulse after the next one
  task automatic pulse(output int n);
    pulse_one(n);
    pulse_one(n);
  endtask
  task automatic pulse_one(output int n);
    int k;
    k = 0;
    n = 0;
    while (gate !== 1'b1 && k < 4000) begin
      cyc(1);
      k++;
    end
    while (gate === 1'b1 && n < 4000) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic int exp_w(input int l);
    return (l < 22) ? 23 : l + 1;
  endfunction
  task automatic ss_wait();
    t = 0;
    while (sink !== 1'b0 && t < 3000) begin
      cyc(1);
      t++;
    end
    near(t, 32 * SS + SYNC, "soft-start length");
    chk(lvl, 5'h1F, "final level");
  endtask
  task automatic end_of_test();
    $display("compares %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #1000000;
    error_cnt++;
    end_of_test();
  end
  initial begin
    cyc(15);
    chk({gate, ramp, blank, lvl, sink, bmode}, 10'h102, "reset values");
    cyc(1);
    rst_i = 1'b0;
    on = 1'b1;
    ok = 1'b1;
    ss_wait();
    $display("soft start done");
    for (int i = 0; i < 6; i++) begin
      fdbk = (i == 0) ? 12'h000 : 12'(10 + {$random(seed)} % 400);
      pulse(w);
      near(w, exp_w(fdbk), "duty width");
    end
    fdbk = 12'hFFF;
    pk = 12'(100 + {$random(seed)} % 300);
    pulse(w);
    near(w, exp_w(pk), "peak width");
    pk = 12'hFFF;
    pulse(w);
    chk(w <= PERIOD_CYC * DMAX_NUM / DMAX_DEN + JITTER_DEPTH_CYC && w > 500, 1'b1, "cap");
    // off time to the next gate rise completes one switching period
    t = 0;
    while (gate !== 1'b1 && t < 4000) begin
      cyc(1);
      t++;
    end
    chk(w + t >= PERIOD_CYC - JITTER_DEPTH_CYC && w + t <= PERIOD_CYC + JITTER_DEPTH_CYC,
      1'b1, "period");
    $display("pwm done");
    lo = 1'b1;
    cyc(BC - 10);
    chk(bmode, 1'b0, "burst early");
    cyc(20);
    chk({bmode, bgate}, 2'h3, "burst entry");
    pulse(w);
    near(w, 61, "burst width");
    lo = 1'b0;
    hi = 1'b1;
    cyc(6);
    chk({bmode, bgate}, 2'h0, "burst exit");
    hi = 1'b0;
    $display("burst done");
    ok = 1'b0;
    on = 1'b0;
    cyc(4);
    w = 0;
    repeat (3000) begin
      cyc(1);
      w += (gate !== 1'b0);
    end
    chk(w, 0, "gate under low supply");
    chk({lvl, sink}, 6'h01, "counter cleared");
    $display("supply done");
    ok = 1'b1;
    on = 1'b1;
    ss_wait();
    rs = 1'b1;
    cyc(4);
    rs = 1'b0;
    chk({lvl, sink}, 6'h01, "restart clears");
    ss_wait();
    $display("restart done");
    end_of_test();
  end
endmodule
